// ==== verilog/smt_pkg.sv ====
`default_nettype none
package smt_pkg;
   // ------------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------------
   localparam logic [3:0] ADDR_TX_STATUS_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_RX_STATUS_CONTROL = 4'h1;
   localparam logic [3:0] ADDR_BAUD_CONTROL = 4'h2;
   localparam logic [3:0] ADDR_BAUD_DIVISOR_LOW = 4'h3;
   localparam logic [3:0] ADDR_BAUD_DIVISOR_HIGH = 4'h4;
   localparam logic [3:0] ADDR_TRANSMIT_BUFFER = 4'h5;
   localparam logic [3:0] ADDR_PERIPH_FLAG_ONE = 4'h6;
   localparam logic [3:0] ADDR_PERIPH_ENABLE_ONE = 4'h7;
   localparam logic [3:0] ADDR_FLAG_CLEAR = 4'h8;
   localparam logic [3:0] ADDR_INTERRUPT_CONTROL = 4'h9;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int BIT_CLOCK_SOURCE_SELECT = 7;
   localparam int BIT_NINTH_BIT_ENABLE = 6;
   localparam int BIT_TRANSMIT_ENABLE = 5;
   localparam int BIT_SYNC_MODE = 4;
   localparam int BIT_SHIFT_REGISTER_EMPTY = 1;
   localparam int BIT_NINTH_BIT_VALUE = 0;
   localparam int BIT_SERIAL_PORT_ENABLE = 7;
   localparam int BIT_TX_CLOCK_POLARITY = 4;
   localparam int BIT_WIDE_BAUD_SELECT = 3;
   localparam int BIT_BUFFER_EMPTY = 4;
   localparam int BIT_CHAR_DONE = 0;
   localparam int BIT_GLOBAL_INT_ENABLE = 7;
   localparam int BIT_PERIPH_INT_ENABLE = 6;

   // ------------------------------------------------------------------
   // Reset values and counts
   // ------------------------------------------------------------------
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [8:0] SHIFT_IDLE = 9'h1ff;
   localparam logic [3:0] BITS_EIGHT = 4'h8;
   localparam logic [3:0] BITS_NINE = 4'h9;
   localparam logic [3:0] BITS_LAST = 4'h1;
   localparam logic [15:0] DIVISOR_ZERO = 16'h0000;

   typedef enum logic [1:0] {
      SMT_IDLE,
      SMT_LOAD,
      SMT_SHIFT
   } smt_state_e;
endpackage : smt_pkg
`default_nettype wire

// ==== verilog/smt_baud_gen.sv ====
`timescale 1ns/1ns
`default_nettype none
module smt_baud_gen (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic restart_in,
   input wire logic wide_in,
   input wire logic [7:0] divisor_high_in,
   input wire logic [7:0] divisor_low_in,
   output logic tick_out
);
   logic [15:0] count_q;
   logic [15:0] count_d;
   logic [15:0] reload;
   logic tick_q;
   logic tick_d;

   // ------------------------------------------------------------------
   // Half-period counter
   // ------------------------------------------------------------------
   // Restarting in the idle and load states makes the first clock phase of every character
   // a full half period long.
   always_comb
   begin
      reload = wide_in ? {divisor_high_in, divisor_low_in} : {smt_pkg::BYTE_ZERO, divisor_low_in};
      count_d = count_q;
      tick_d = 1'b0;
      if (restart_in)
      begin
         count_d = reload;
      end
      else if (count_q == smt_pkg::DIVISOR_ZERO)
      begin
         count_d = reload;
         tick_d = 1'b1;
      end
      else
      begin
         count_d = count_q - 16'h0001;
      end
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         count_q <= smt_pkg::DIVISOR_ZERO;
         tick_q <= 1'b0;
      end
      else
      begin
         count_q <= count_d;
         tick_q <= tick_d;
      end
   end

   assign tick_out = tick_q;
endmodule : smt_baud_gen
`default_nettype wire

// ==== verilog/smt_tx_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module smt_tx_top (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic [3:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   input wire logic rx_busy_in,
   output logic tx_busy_out,
   output logic shift_timing_pin_out,
   output logic shift_timing_pin_oe_out,
   output logic serial_data_pin_out,
   output logic serial_data_pin_oe_out,
   output logic irq_out
);
   // ------------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------------
   logic clock_source_select_q, clock_source_select_d;
   logic ninth_bit_enable_q, ninth_bit_enable_d;
   logic transmit_enable_q, transmit_enable_d;
   logic sync_mode_q, sync_mode_d;
   logic ninth_bit_value_q, ninth_bit_value_d;
   logic serial_port_enable_q, serial_port_enable_d;
   logic tx_clock_polarity_q, tx_clock_polarity_d;
   logic wide_baud_select_q, wide_baud_select_d;
   logic [7:0] baud_divisor_low_q, baud_divisor_low_d;
   logic [7:0] baud_divisor_high_q, baud_divisor_high_d;
   logic transmit_interrupt_enable_q, transmit_interrupt_enable_d;
   logic done_interrupt_enable_q, done_interrupt_enable_d;
   logic global_interrupt_enable_q, global_interrupt_enable_d;
   logic peripheral_interrupt_enable_q, peripheral_interrupt_enable_d;

   function automatic logic hit(input logic [3:0] addr, input logic [3:0] offset);
      hit = (addr == offset);
   endfunction : hit

   logic wr_tx_status, wr_rx_status, wr_baud_control, wr_buffer, wr_clear;
   logic tx_on;

   always_comb
   begin
      wr_tx_status = reg_wr_in && hit(reg_addr_in, smt_pkg::ADDR_TX_STATUS_CONTROL);
      wr_rx_status = reg_wr_in && hit(reg_addr_in, smt_pkg::ADDR_RX_STATUS_CONTROL);
      wr_baud_control = reg_wr_in && hit(reg_addr_in, smt_pkg::ADDR_BAUD_CONTROL);
      wr_buffer = reg_wr_in && hit(reg_addr_in, smt_pkg::ADDR_TRANSMIT_BUFFER);
      wr_clear = reg_wr_in && hit(reg_addr_in, smt_pkg::ADDR_FLAG_CLEAR);
      clock_source_select_d = clock_source_select_q;
      ninth_bit_enable_d = ninth_bit_enable_q;
      transmit_enable_d = transmit_enable_q;
      sync_mode_d = sync_mode_q;
      ninth_bit_value_d = ninth_bit_value_q;
      serial_port_enable_d = serial_port_enable_q;
      tx_clock_polarity_d = tx_clock_polarity_q;
      wide_baud_select_d = wide_baud_select_q;
      baud_divisor_low_d = baud_divisor_low_q;
      baud_divisor_high_d = baud_divisor_high_q;
      transmit_interrupt_enable_d = transmit_interrupt_enable_q;
      done_interrupt_enable_d = done_interrupt_enable_q;
      global_interrupt_enable_d = global_interrupt_enable_q;
      peripheral_interrupt_enable_d = peripheral_interrupt_enable_q;
      if (wr_tx_status)
      begin
         clock_source_select_d = reg_wdata_in[smt_pkg::BIT_CLOCK_SOURCE_SELECT];
         ninth_bit_enable_d = reg_wdata_in[smt_pkg::BIT_NINTH_BIT_ENABLE];
         transmit_enable_d = reg_wdata_in[smt_pkg::BIT_TRANSMIT_ENABLE];
         sync_mode_d = reg_wdata_in[smt_pkg::BIT_SYNC_MODE];
         ninth_bit_value_d = reg_wdata_in[smt_pkg::BIT_NINTH_BIT_VALUE];
      end
      if (wr_rx_status)
      begin
         serial_port_enable_d = reg_wdata_in[smt_pkg::BIT_SERIAL_PORT_ENABLE];
      end
      if (wr_baud_control)
      begin
         tx_clock_polarity_d = reg_wdata_in[smt_pkg::BIT_TX_CLOCK_POLARITY];
         wide_baud_select_d = reg_wdata_in[smt_pkg::BIT_WIDE_BAUD_SELECT];
      end
      if (reg_wr_in && hit(reg_addr_in, smt_pkg::ADDR_BAUD_DIVISOR_LOW))
      begin
         baud_divisor_low_d = reg_wdata_in;
      end
      if (reg_wr_in && hit(reg_addr_in, smt_pkg::ADDR_BAUD_DIVISOR_HIGH))
      begin
         baud_divisor_high_d = reg_wdata_in;
      end
      if (reg_wr_in && hit(reg_addr_in, smt_pkg::ADDR_PERIPH_ENABLE_ONE))
      begin
         transmit_interrupt_enable_d = reg_wdata_in[smt_pkg::BIT_BUFFER_EMPTY];
         done_interrupt_enable_d = reg_wdata_in[smt_pkg::BIT_CHAR_DONE];
      end
      if (reg_wr_in && hit(reg_addr_in, smt_pkg::ADDR_INTERRUPT_CONTROL))
      begin
         global_interrupt_enable_d = reg_wdata_in[smt_pkg::BIT_GLOBAL_INT_ENABLE];
         peripheral_interrupt_enable_d = reg_wdata_in[smt_pkg::BIT_PERIPH_INT_ENABLE];
      end
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         clock_source_select_q <= 1'b0;
         ninth_bit_enable_q <= 1'b0;
         transmit_enable_q <= 1'b0;
         sync_mode_q <= 1'b0;
         ninth_bit_value_q <= 1'b0;
         serial_port_enable_q <= 1'b0;
         tx_clock_polarity_q <= 1'b0;
         wide_baud_select_q <= 1'b0;
         baud_divisor_low_q <= smt_pkg::BYTE_ZERO;
         baud_divisor_high_q <= smt_pkg::BYTE_ZERO;
         transmit_interrupt_enable_q <= 1'b0;
         done_interrupt_enable_q <= 1'b0;
         global_interrupt_enable_q <= 1'b0;
         peripheral_interrupt_enable_q <= 1'b0;
      end
      else
      begin
         clock_source_select_q <= clock_source_select_d;
         ninth_bit_enable_q <= ninth_bit_enable_d;
         transmit_enable_q <= transmit_enable_d;
         sync_mode_q <= sync_mode_d;
         ninth_bit_value_q <= ninth_bit_value_d;
         serial_port_enable_q <= serial_port_enable_d;
         tx_clock_polarity_q <= tx_clock_polarity_d;
         wide_baud_select_q <= wide_baud_select_d;
         baud_divisor_low_q <= baud_divisor_low_d;
         baud_divisor_high_q <= baud_divisor_high_d;
         transmit_interrupt_enable_q <= transmit_interrupt_enable_d;
         done_interrupt_enable_q <= done_interrupt_enable_d;
         global_interrupt_enable_q <= global_interrupt_enable_d;
         peripheral_interrupt_enable_q <= peripheral_interrupt_enable_d;
      end
   end

   // Master, synchronous, pins claimed and transmit enabled.
   assign tx_on = clock_source_select_q && sync_mode_q && serial_port_enable_q
                  && transmit_enable_q;

   // ------------------------------------------------------------------
   // Transmit buffer, shift register and sequencer
   // ------------------------------------------------------------------
   smt_pkg::smt_state_e state_q, state_d;
   logic [7:0] buffer_q, buffer_d;
   logic buffer_full_q, buffer_full_d;
   logic [8:0] shift_q, shift_d;
   logic [3:0] bits_left_q, bits_left_d;
   logic phase_q, phase_d;
   logic clock_pin_q, clock_pin_d;
   logic char_done_q, char_done_d;
   logic half_tick;
   logic char_end;

   smt_baud_gen u_baud (
      .clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in),
      .restart_in(state_q != smt_pkg::SMT_SHIFT),
      .wide_in(wide_baud_select_q),
      .divisor_high_in(baud_divisor_high_q),
      .divisor_low_in(baud_divisor_low_q),
      .tick_out(half_tick)
   );

   always_comb
   begin
      state_d = state_q;
      shift_d = shift_q;
      bits_left_d = bits_left_q;
      phase_d = phase_q;
      char_end = 1'b0;
      buffer_d = wr_buffer ? reg_wdata_in : buffer_q;
      case (state_q)
         smt_pkg::SMT_IDLE:
         begin
            if (tx_on && buffer_full_q && !rx_busy_in)
            begin
               state_d = smt_pkg::SMT_LOAD;
            end
         end
         smt_pkg::SMT_LOAD:
         begin
            shift_d = {ninth_bit_value_q, buffer_q};
            bits_left_d = ninth_bit_enable_q ? smt_pkg::BITS_NINE : smt_pkg::BITS_EIGHT;
            phase_d = 1'b0;
            state_d = smt_pkg::SMT_SHIFT;
         end
         smt_pkg::SMT_SHIFT:
         begin
            // Dropping any enable aborts the character mid-way.
            if (!tx_on)
            begin
               state_d = smt_pkg::SMT_IDLE;
               shift_d = smt_pkg::SHIFT_IDLE;
            end
            else if (half_tick && !phase_q)
            begin
               phase_d = 1'b1;
            end
            else if (half_tick)
            begin
               phase_d = 1'b0;
               shift_d = {1'b1, shift_q[8:1]};
               bits_left_d = bits_left_q - 4'h1;
               if (bits_left_q == smt_pkg::BITS_LAST)
               begin
                  char_end = 1'b1;
                  // Back-to-back characters reload at once.
                  state_d = (buffer_full_q && !rx_busy_in) ? smt_pkg::SMT_LOAD
                                                           : smt_pkg::SMT_IDLE;
               end
            end
         end
         default:
         begin
            state_d = smt_pkg::SMT_IDLE;
         end
      endcase
      // A write in the transfer cycle refills the buffer: the set wins.
      if (wr_buffer)
      begin
         buffer_full_d = 1'b1;
      end
      else if (state_q == smt_pkg::SMT_LOAD)
      begin
         buffer_full_d = 1'b0;
      end
      else
      begin
         buffer_full_d = buffer_full_q;
      end
      clock_pin_d = (state_d == smt_pkg::SMT_SHIFT && phase_d) ? !tx_clock_polarity_d
                                                             : tx_clock_polarity_d;
      char_done_d = char_end || (char_done_q
                    && !(wr_clear && reg_wdata_in[smt_pkg::BIT_CHAR_DONE]));
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         state_q <= smt_pkg::SMT_IDLE;
         buffer_q <= smt_pkg::BYTE_ZERO;
         buffer_full_q <= 1'b0;
         shift_q <= smt_pkg::SHIFT_IDLE;
         bits_left_q <= 4'h0;
         phase_q <= 1'b0;
         clock_pin_q <= 1'b0;
         char_done_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         buffer_q <= buffer_d;
         buffer_full_q <= buffer_full_d;
         shift_q <= shift_d;
         bits_left_q <= bits_left_d;
         phase_q <= phase_d;
         clock_pin_q <= clock_pin_d;
         char_done_q <= char_done_d;
      end
   end

   // ------------------------------------------------------------------
   // Pins, status and interrupt
   // ------------------------------------------------------------------
   logic buffer_empty_flag;
   logic shift_register_empty;

   assign buffer_empty_flag = !buffer_full_q;
   assign shift_register_empty = (state_q != smt_pkg::SMT_SHIFT);
   assign tx_busy_out = (state_q != smt_pkg::SMT_IDLE);
   assign shift_timing_pin_out = clock_pin_q;
   assign shift_timing_pin_oe_out = serial_port_enable_q && sync_mode_q
                                    && clock_source_select_q;
   assign serial_data_pin_out = shift_q[0];
   assign serial_data_pin_oe_out = tx_on;
   assign irq_out = global_interrupt_enable_q && peripheral_interrupt_enable_q
                    && ((buffer_empty_flag && transmit_interrupt_enable_q)
                    || (char_done_q && done_interrupt_enable_q));

   // ------------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------------
   logic [7:0] rdata_q, rdata_d;

   always_comb
   begin
      rdata_d = smt_pkg::BYTE_ZERO;
      if (reg_rd_in)
      begin
         // No offset reaches the shift register itself.
         case (reg_addr_in)
            smt_pkg::ADDR_TX_STATUS_CONTROL:
            begin
               rdata_d[smt_pkg::BIT_CLOCK_SOURCE_SELECT] = clock_source_select_q;
               rdata_d[smt_pkg::BIT_NINTH_BIT_ENABLE] = ninth_bit_enable_q;
               rdata_d[smt_pkg::BIT_TRANSMIT_ENABLE] = transmit_enable_q;
               rdata_d[smt_pkg::BIT_SYNC_MODE] = sync_mode_q;
               rdata_d[smt_pkg::BIT_SHIFT_REGISTER_EMPTY] = shift_register_empty;
               rdata_d[smt_pkg::BIT_NINTH_BIT_VALUE] = ninth_bit_value_q;
            end
            smt_pkg::ADDR_RX_STATUS_CONTROL:
               rdata_d[smt_pkg::BIT_SERIAL_PORT_ENABLE] = serial_port_enable_q;
            smt_pkg::ADDR_BAUD_CONTROL:
            begin
               rdata_d[smt_pkg::BIT_TX_CLOCK_POLARITY] = tx_clock_polarity_q;
               rdata_d[smt_pkg::BIT_WIDE_BAUD_SELECT] = wide_baud_select_q;
            end
            smt_pkg::ADDR_BAUD_DIVISOR_LOW: rdata_d = baud_divisor_low_q;
            smt_pkg::ADDR_BAUD_DIVISOR_HIGH: rdata_d = baud_divisor_high_q;
            smt_pkg::ADDR_TRANSMIT_BUFFER: rdata_d = buffer_q;
            smt_pkg::ADDR_PERIPH_FLAG_ONE:
            begin
               rdata_d[smt_pkg::BIT_BUFFER_EMPTY] = buffer_empty_flag;
               rdata_d[smt_pkg::BIT_CHAR_DONE] = char_done_q;
            end
            smt_pkg::ADDR_PERIPH_ENABLE_ONE:
            begin
               rdata_d[smt_pkg::BIT_BUFFER_EMPTY] = transmit_interrupt_enable_q;
               rdata_d[smt_pkg::BIT_CHAR_DONE] = done_interrupt_enable_q;
            end
            smt_pkg::ADDR_INTERRUPT_CONTROL:
            begin
               rdata_d[smt_pkg::BIT_GLOBAL_INT_ENABLE] = global_interrupt_enable_q;
               rdata_d[smt_pkg::BIT_PERIPH_INT_ENABLE] = peripheral_interrupt_enable_q;
            end
            default: rdata_d = smt_pkg::BYTE_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         rdata_q <= smt_pkg::BYTE_ZERO;
      end
      else
      begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata_out = rdata_q;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   mode_gate_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      state_q == smt_pkg::SMT_LOAD |-> $past(clock_source_select_q && sync_mode_q))
      else $error("load without master synchronous mode");
   half_duplex_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      state_q == smt_pkg::SMT_LOAD |-> !$past(rx_busy_in))
      else $error("transfer began during reception");
   idle_clock_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (state_q == smt_pkg::SMT_IDLE && $past(state_q == smt_pkg::SMT_IDLE)
       && $stable(tx_clock_polarity_q)) |-> shift_timing_pin_out == tx_clock_polarity_q)
      else $error("clock pin not at idle level");
   clock_active_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (state_q == smt_pkg::SMT_SHIFT && phase_q) |-> shift_timing_pin_out != tx_clock_polarity_q)
      else $error("clock pin not active in second half");
   load_one_cycle_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (state_q == smt_pkg::SMT_LOAD && !wr_buffer) |=> buffer_empty_flag
                                                   && state_q == smt_pkg::SMT_SHIFT)
      else $error("buffer not empty one cycle after transfer");
   flag_clear_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      $fell(buffer_empty_flag) |-> $past(wr_buffer))
      else $error("buffer empty flag cleared without a buffer write");
   reload_after_last_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (state_q == smt_pkg::SMT_SHIFT ##1 state_q == smt_pkg::SMT_LOAD)
      |-> $past(char_end))
      else $error("shift register reloaded before last bit");
   lsb_first_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (state_q == smt_pkg::SMT_SHIFT && tx_on && half_tick && phase_q)
      |=> serial_data_pin_out == $past(shift_q[1]))
      else $error("data line did not advance to next bit");
   start_shift_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (wr_buffer && tx_on && !buffer_full_q && state_q == smt_pkg::SMT_IDLE)
      ##1 (tx_on && !rx_busy_in)
      |=> state_q == smt_pkg::SMT_LOAD)
      else $error("buffer load did not start shifting");
   nine_bits_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (state_q == smt_pkg::SMT_LOAD && ninth_bit_enable_q)
      |=> bits_left_q == smt_pkg::BITS_NINE && shift_q[8] == $past(ninth_bit_value_q))
      else $error("ninth bit not loaded");
   irq_gate_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (buffer_empty_flag && !transmit_interrupt_enable_q && !char_done_q) |-> !irq_out)
      else $error("interrupt raised with transmit interrupt disabled");
endmodule : smt_tx_top
`default_nettype wire

// ==== bench/smt_slave_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module smt_slave_model (
   input wire logic clk_in,
   input wire logic pol_in,
   input wire logic sck_in,
   input wire logic sdo_in,
   output logic [8:0] word_out,
   output int bits_out
);
   logic last_q = 1'b0;
   logic [8:0] word_q = 9'h000;
   int bits_q = 0;
   assign word_out = word_q;
   assign bits_out = bits_q;
   // Bits are taken as the clock leaves idle, mid-bit, so a skewed edge still sees stable data.
   always @(posedge clk_in)
   begin
      if (sck_in != last_q && sck_in != pol_in)
      begin
         word_q <= {sdo_in, word_q[8:1]};
         bits_q <= bits_q + 1;
      end
      last_q <= sck_in;
   end
endmodule : smt_slave_model
`default_nettype wire

// ==== bench/sync_master_serial_transmit_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module sync_master_serial_transmit_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic rx_busy = 1'b0;
   logic pol = 1'b0;
   logic [7:0] rdata;
   logic busy, sck, sck_oe, sdo, sdo_oe, irq;
   logic [8:0] word;
   int bits;
   int k0;
   int mismatches = 0;
   int cmp_count = 0;
   always #25 clk = ~clk;
   smt_tx_top DUT (.clk_sys_in(clk), .sys_rst_in(rst), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
      .rx_busy_in(rx_busy), .tx_busy_out(busy), .shift_timing_pin_out(sck),
      .shift_timing_pin_oe_out(sck_oe), .serial_data_pin_out(sdo),
      .serial_data_pin_oe_out(sdo_oe), .irq_out(irq));
   smt_slave_model peer (.clk_in(clk), .pol_in(pol), .sck_in(sck), .sdo_in(sdo),
      .word_out(word), .bits_out(bits));
   task automatic test_done();
      if (mismatches == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : test_done
   task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      @(negedge clk);
      chk("rdata", {1'b0, rdata}, {1'b0, e});
      @(posedge clk);
   endtask : rd
   function automatic logic [8:0] exp_word(input logic [7:0] b, input logic n9);
      return {n9 & ~b[0], b};
   endfunction : exp_word
   // The ninth value is the inverse of bit 0 so a stuck ninth bit cannot pass.
   task automatic send(input logic [7:0] b, input logic [2:0] m, input logic [1:0] dv);
      int k;
      int n;
      int j;
      k = bits;
      n = (m[1] ? 9 : 8) * (m[2] ? 2 : 1);
      pol <= m[0];
      wr(smt_pkg::ADDR_BAUD_CONTROL, {3'b000, m[0], 4'h0});
      wr(smt_pkg::ADDR_BAUD_DIVISOR_LOW, {6'h00, dv});
      wr(smt_pkg::ADDR_TX_STATUS_CONTROL, {1'b1, m[1], 5'h18, ~b[0]});
      wr(smt_pkg::ADDR_TRANSMIT_BUFFER, b);
      if (m[2])
      begin
         repeat (4) @(posedge clk);
         wr(smt_pkg::ADDR_TRANSMIT_BUFFER, b);
      end
      for (j = 0; j < 3000 && bits != k + n; j++)
         @(posedge clk);
      for (j = 0; j < 99 && busy !== 1'b0; j++)
         @(posedge clk);
      @(negedge clk);
      chk("bits", 9'(bits - k), 9'(n));
      chk("word", m[1] ? word : {1'b0, word[8:1]}, exp_word(b, m[1]));
      chk("idle", {8'h00, sck}, {8'h00, m[0]});
      @(posedge clk);
   endtask : send
   initial
   begin
      void'($urandom(46221));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(smt_pkg::ADDR_PERIPH_FLAG_ONE, 8'h10);
      wr(smt_pkg::ADDR_RX_STATUS_CONTROL, 8'h80);
      wr(smt_pkg::ADDR_TX_STATUS_CONTROL, 8'hb0);
      rd(smt_pkg::ADDR_TX_STATUS_CONTROL, 8'hb2);
      wr(smt_pkg::ADDR_PERIPH_ENABLE_ONE, 8'h10);
      wr(smt_pkg::ADDR_INTERRUPT_CONTROL, 8'hc0);
      chk("irq", {8'h00, irq}, 9'h001);
      chk("oe", {7'h00, sck_oe, sdo_oe}, 9'h003);
      rx_busy <= 1'b1;
      wr(smt_pkg::ADDR_TRANSMIT_BUFFER, 8'ha5);
      repeat (8) @(posedge clk);
      chk("busy", {8'h00, busy}, 9'h000);
      wr(smt_pkg::ADDR_FLAG_CLEAR, 8'h10);
      rd(smt_pkg::ADDR_PERIPH_FLAG_ONE, 8'h00);
      chk("irq", {8'h00, irq}, 9'h000);
      rd(4'hf, 8'h00);
      // The character held back by reception must go out once reception ends.
      k0 = bits;
      rx_busy <= 1'b0;
      for (int j = 0; j < 300 && (bits != k0 + 8 || busy !== 1'b0); j++)
         @(posedge clk);
      chk("held bits", 9'(bits - k0), 9'h008);
      chk("held word", {1'b0, word[8:1]}, 9'h0a5);
      send(8'ha5, 3'b000, 2'd0);
      rd(smt_pkg::ADDR_PERIPH_FLAG_ONE, 8'h11);
      wr(smt_pkg::ADDR_FLAG_CLEAR, 8'h11);
      rd(smt_pkg::ADDR_PERIPH_FLAG_ONE, 8'h10);
      wr(smt_pkg::ADDR_INTERRUPT_CONTROL, 8'h40);
      chk("irq", {8'h00, irq}, 9'h000);
      for (int i = 0; i < 12; i++)
         send(8'($urandom), 3'(i), 2'($urandom % 3));
      wr(smt_pkg::ADDR_TX_STATUS_CONTROL, 8'h30);
      chk("oe off", {7'h00, sck_oe, sdo_oe}, 9'h000);
      test_done();
   end
   initial
   begin
      #1000000;
      mismatches++;
      test_done();
   end
endmodule : sync_master_serial_transmit_bench
`default_nettype wire
